// *** core/ecio_cfg.svh ***
`ifndef ECIO_CFG_SVH
`define ECIO_CFG_SVH
// Behaviour
// - Address bit 21 low selects a handshake card, high the strobe engine.
// - Grant is open-drain: agents only pull it low or release it.
// - Buffer enables stay driven even in handshake cycles for other targets.
// - Host starts a cycle with request low and holds processor clocks.
// - Request low at a rising edge, with grant low two rising edges before, ends cycle next falling edge.
// - Handshake timing uses whole periods of the 8 MHz reference clock.
// - The first request of a cycle is asserted on the falling edge after the start arrives.
// - Pending DMA or refresh raises request; it returns low when none pend.
// - Requests resumed after a pause are asserted on a falling edge.
// - Processor data drive enable is held low while a handshake cycle is paused for DMA or refresh.
// - A pause lasts at most 1875 ns, fifteen reference periods.
// - Without a grant the processor clocks stay held until reset.
// - Strobe follows select by 187 ns slow, 62 ns medium and fast.
// - Strobe lasts 375, 375, 250 ns; select 625, 500, 375 ns.
// - A synchronous strobe cycle lasts at least 500 ns.
`define ECIO_CLK_NS 25
`define ECIO_REF_NS 125
`define ECIO_UP(ns) (((ns) + `ECIO_CLK_NS - 1) / `ECIO_CLK_NS)
`define ECIO_OWNER_BIT 21
`define ECIO_SLOW_LEAD_NS 187
`define ECIO_MF_LEAD_NS 62
`define ECIO_SM_STROBE_NS 375
`define ECIO_FAST_STROBE_NS 250
`define ECIO_SLOW_SEL_NS 625
`define ECIO_MED_SEL_NS 500
`define ECIO_FAST_SEL_NS 375
`define ECIO_SYNC_CYCLE_NS 500
`define ECIO_PAUSE_MAX_NS 1875
`define ECIO_PAUSE_MAX_CYC (`ECIO_PAUSE_MAX_NS / `ECIO_REF_NS)
`endif

// *** core/ecio_pkg.sv ***
package ecio_pkg;
	typedef enum logic [1:0] {
		ECIO_HS_IDLE  = 2'b00,
		ECIO_HS_REQ   = 2'b01,
		ECIO_HS_PAUSE = 2'b10
	} ecio_hs_state_type;
	typedef enum logic [1:0] {
		ECIO_SLOW   = 2'b00,
		ECIO_MEDIUM = 2'b01,
		ECIO_FAST   = 2'b10,
		ECIO_SYNC   = 2'b11
	} ecio_kind_type;
	typedef struct packed {
		logic [23:0]   addr;
		logic          rnw;
		ecio_kind_type kind;
	} ecio_cpu_req_type;
endpackage

// *** core/ecio_host.sv ***
`timescale 1ns/1ps
`include "ecio_cfg.svh"
module ecio_host import ecio_pkg::*; #(
	parameter int PAUSE_MAX = `ECIO_PAUSE_MAX_CYC
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             ref_clock_8m,
	input  wire ecio_cpu_req_type cpu_req,
	input  wire logic             cpu_req_valid,
	output logic                  cpu_req_ready,
	output logic                  cpu_done,
	output logic                  cpu_clock_hold,
	input  wire logic             processor_phase_two,
	input  wire logic             dma_refresh_pending,
	output logic [23:0]           io_address_bus,
	output logic                  read_not_write,
	output logic                  io_request_n,
	input  wire logic             io_grant_n_i,
	output logic                  io_grant_n_o,
	output logic                  io_grant_n_oe,
	output logic                  handshake_card_select_n,
	output logic                  read_buffer_enable_n,
	output logic                  write_buffer_enable_n,
	output logic                  cpu_data_drive_enable_n,
	output logic                  card_select_n,
	output logic                  card_read_strobe_n,
	output logic                  card_write_strobe_n
);

	// The pause counter is four bits wide and cannot serve a cap above 15.
	if (PAUSE_MAX < 1 || PAUSE_MAX > 15) begin : g_bad_pause
		$error("PAUSE_MAX must lie in 1..15");
	end

	localparam logic [3:0] PAUSE_LAST = 4'(PAUSE_MAX - 1);

	function automatic logic [4:0] lead_cyc(input ecio_kind_type k);
		case (k)
			ECIO_SLOW: lead_cyc = 5'(`ECIO_UP(`ECIO_SLOW_LEAD_NS));
			ECIO_SYNC: lead_cyc = 5'h00;
			default:   lead_cyc = 5'(`ECIO_UP(`ECIO_MF_LEAD_NS));
		endcase
	endfunction

	function automatic logic [4:0] strobe_cyc(input ecio_kind_type k);
		case (k)
			ECIO_FAST: strobe_cyc = 5'(`ECIO_UP(`ECIO_FAST_STROBE_NS));
			ECIO_SYNC: strobe_cyc = 5'(`ECIO_UP(`ECIO_SYNC_CYCLE_NS));
			default:   strobe_cyc = 5'(`ECIO_UP(`ECIO_SM_STROBE_NS));
		endcase
	endfunction

	function automatic logic [4:0] select_cyc(input ecio_kind_type k);
		case (k)
			ECIO_SLOW:   select_cyc = 5'(`ECIO_UP(`ECIO_SLOW_SEL_NS));
			ECIO_MEDIUM: select_cyc = 5'(`ECIO_UP(`ECIO_MED_SEL_NS));
			ECIO_FAST:   select_cyc = 5'(`ECIO_UP(`ECIO_FAST_SEL_NS));
			default:     select_cyc = 5'(`ECIO_UP(`ECIO_SYNC_CYCLE_NS));
		endcase
	endfunction

	// System clock domain: request intake and strobe engine.
	ecio_cpu_req_type  req_q;
	logic              ready_q;
	logic              done_q;
	logic              hold_q;
	logic              start_tgl_q;
	logic              ph2_m_q;
	logic              ph2_s_q;
	logic              done_m_q;
	logic              done_s_q;
	logic              done_seen_q;
	logic              done_tgl_q;
	logic              sel_n_q;
	logic              rd_n_q;
	logic              wr_n_q;
	logic              gnt_oe_q;
	logic              gnt_o_q;
	logic [4:0]        cnt_q;
	logic              accept;
	logic              done_evt;

	// Processor clocks are only stretched while phase two is high.
	assign accept   = cpu_req_valid && ready_q && ph2_s_q;
	assign done_evt = done_s_q ^ done_seen_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ph2_m_q     <= 1'b0;
			ph2_s_q     <= 1'b0;
			done_m_q    <= 1'b0;
			done_s_q    <= 1'b0;
			done_seen_q <= 1'b0;
		end else begin
			ph2_m_q     <= processor_phase_two;
			ph2_s_q     <= ph2_m_q;
			done_m_q    <= done_tgl_q;
			done_s_q    <= done_m_q;
			done_seen_q <= done_s_q;
		end
	end

	// The request word stays frozen while busy, so the link side may read
	// it once the start toggle has crossed.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			req_q       <= '0;
			ready_q     <= 1'b1;
			done_q      <= 1'b0;
			hold_q      <= 1'b0;
			start_tgl_q <= 1'b0;
		end else begin
			done_q <= done_evt;
			if (accept) begin
				req_q       <= cpu_req;
				ready_q     <= 1'b0;
				hold_q      <= 1'b1;
				start_tgl_q <= ~start_tgl_q;
			end else if (done_evt) begin
				ready_q <= 1'b1;
				hold_q  <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sel_n_q  <= 1'b1;
			rd_n_q   <= 1'b1;
			wr_n_q   <= 1'b1;
			gnt_oe_q <= 1'b0;
			gnt_o_q  <= 1'b0;
			cnt_q    <= 5'h00;
		end else begin
			gnt_o_q <= 1'b0;
			if (accept && cpu_req.addr[`ECIO_OWNER_BIT]) begin
				sel_n_q <= 1'b0;
				cnt_q   <= 5'h00;
				if (lead_cyc(cpu_req.kind) == 5'h00) begin
					rd_n_q <= ~cpu_req.rnw;
					wr_n_q <= cpu_req.rnw;
				end
			end else if (!sel_n_q) begin
				cnt_q <= cnt_q + 5'h01;
				if (cnt_q + 5'h01 == lead_cyc(req_q.kind)) begin
					rd_n_q <= ~req_q.rnw;
					wr_n_q <= req_q.rnw;
				end
				if (cnt_q + 5'h01 == lead_cyc(req_q.kind)
				    + strobe_cyc(req_q.kind)) begin
					rd_n_q <= 1'b1;
					wr_n_q <= 1'b1;
				end
				if (cnt_q + 5'h01 == select_cyc(req_q.kind)) begin
					sel_n_q  <= 1'b1;
					// The strobe access is over; finish the handshake.
					gnt_oe_q <= 1'b1;
				end
			end
			if (done_evt)
				gnt_oe_q <= 1'b0;
		end
	end

	// Link domain on the reference clock: rising edges sample, falling
	// edges drive request, so every cycle is whole reference periods.
	ecio_hs_state_type st_q;
	logic              st_m_q;
	logic              st_s_q;
	logic              gnt_m_q;
	logic              gnt_s_q;
	logic              dma_m_q;
	logic              dma_s_q;
	logic              cmpl_q;
	logic              start_seen_q;
	logic              req_n_q;
	logic              ms_n_q;
	logic              rbe_n_q;
	logic              wbe_n_q;
	logic              dbe_n_q;
	logic [3:0]        pcnt_q;

	always_ff @(posedge ref_clock_8m or negedge rstn) begin
		if (!rstn) begin
			st_m_q  <= 1'b0;
			st_s_q  <= 1'b0;
			gnt_m_q <= 1'b1;
			gnt_s_q <= 1'b1;
			dma_m_q <= 1'b0;
			dma_s_q <= 1'b0;
			cmpl_q  <= 1'b0;
		end else begin
			st_m_q  <= start_tgl_q;
			st_s_q  <= st_m_q;
			gnt_m_q <= io_grant_n_i;
			gnt_s_q <= gnt_m_q;
			dma_m_q <= dma_refresh_pending;
			dma_s_q <= dma_m_q;
			cmpl_q  <= st_q == ECIO_HS_REQ && !req_n_q && !gnt_s_q;
		end
	end

	always_ff @(negedge ref_clock_8m or negedge rstn) begin
		if (!rstn) begin
			st_q         <= ECIO_HS_IDLE;
			start_seen_q <= 1'b0;
			done_tgl_q   <= 1'b0;
			req_n_q      <= 1'b1;
			ms_n_q       <= 1'b1;
			rbe_n_q      <= 1'b1;
			wbe_n_q      <= 1'b1;
			dbe_n_q      <= 1'b1;
			pcnt_q       <= 4'h0;
		end else begin
			case (st_q)
				ECIO_HS_IDLE: begin
					// Taken on the first falling edge after the start
					// arrives, before any pause can be considered.
					if (st_s_q != start_seen_q) begin
						start_seen_q <= st_s_q;
						st_q         <= ECIO_HS_REQ;
						req_n_q      <= 1'b0;
						ms_n_q       <= req_q.addr[`ECIO_OWNER_BIT];
						rbe_n_q      <= ~req_q.rnw;
						wbe_n_q      <= req_q.rnw;
					end
				end
				ECIO_HS_REQ: begin
					if (cmpl_q) begin
						st_q       <= ECIO_HS_IDLE;
						req_n_q    <= 1'b1;
						ms_n_q     <= 1'b1;
						rbe_n_q    <= 1'b1;
						wbe_n_q    <= 1'b1;
						done_tgl_q <= ~done_tgl_q;
					end else if (dma_s_q) begin
						st_q    <= ECIO_HS_PAUSE;
						req_n_q <= 1'b1;
						rbe_n_q <= 1'b1;
						dbe_n_q <= 1'b0;
						pcnt_q  <= 4'h0;
					end
				end
				ECIO_HS_PAUSE: begin
					pcnt_q <= pcnt_q + 4'h1;
					// The pause is capped so that card logic never sees
					// a longer interruption than it must tolerate.
					if (!dma_s_q || pcnt_q == PAUSE_LAST) begin
						st_q    <= ECIO_HS_REQ;
						req_n_q <= 1'b0;
						rbe_n_q <= ~req_q.rnw;
						dbe_n_q <= 1'b1;
					end
				end
				default: st_q <= ECIO_HS_IDLE;
			endcase
		end
	end

	assign cpu_req_ready           = ready_q;
	assign cpu_done                = done_q;
	assign cpu_clock_hold          = hold_q;
	assign io_address_bus          = req_q.addr;
	assign read_not_write          = req_q.rnw;
	assign io_request_n            = req_n_q;
	assign io_grant_n_o            = gnt_o_q;
	assign io_grant_n_oe           = gnt_oe_q;
	assign handshake_card_select_n = ms_n_q;
	assign read_buffer_enable_n    = rbe_n_q;
	assign write_buffer_enable_n   = wbe_n_q;
	assign cpu_data_drive_enable_n = dbe_n_q;
	assign card_select_n           = sel_n_q;
	assign card_read_strobe_n      = rd_n_q;
	assign card_write_strobe_n     = wr_n_q;

	a_select_owner: assert property (@(posedge clk) disable iff (!rstn)
		!sel_n_q |-> req_q.addr[`ECIO_OWNER_BIT])
		else $error("card select active for a handshake address");
	a_grant_low_only: assert property (@(posedge clk) disable iff (!rstn)
		gnt_oe_q |-> !gnt_o_q && sel_n_q && !ready_q)
		else $error("grant driven high or outside a strobe cycle");
	a_buffer_enable: assert property (@(negedge ref_clock_8m)
		disable iff (!rstn)
		$fell(req_n_q) |-> (rbe_n_q != wbe_n_q))
		else $error("buffer enables not driven with request");
	a_hold_start: assert property (@(posedge clk) disable iff (!rstn)
		accept |=> hold_q && !ready_q)
		else $error("processor clocks not held at cycle start");
	a_cmpl_release: assert property (@(negedge ref_clock_8m)
		disable iff (!rstn)
		st_q == ECIO_HS_REQ && cmpl_q |=> req_n_q && st_q == ECIO_HS_IDLE)
		else $error("request not raised after completion");
	a_pause_raise: assert property (@(negedge ref_clock_8m)
		disable iff (!rstn)
		st_q == ECIO_HS_REQ && !cmpl_q && dma_s_q |=> req_n_q && !dbe_n_q)
		else $error("pending DMA did not pause the request");
	a_pause_bound: assert property (@(negedge ref_clock_8m)
		disable iff (!rstn)
		$rose(req_n_q) && st_q == ECIO_HS_PAUSE |-> ##[1:15] !req_n_q)
		else $error("pause exceeded fifteen reference periods");
	a_wait_grant: assert property (@(negedge ref_clock_8m)
		disable iff (!rstn)
		st_q == ECIO_HS_REQ && !cmpl_q |=> st_q != ECIO_HS_IDLE)
		else $error("cycle ended without a grant");
	a_slow_lead: assert property (@(posedge clk) disable iff (!rstn)
		$fell(sel_n_q) && req_q.kind == ECIO_SLOW
		|-> (rd_n_q && wr_n_q)[*8] ##1 !(rd_n_q && wr_n_q))
		else $error("slow strobe lead is not eight cycles");
	a_fast_select: assert property (@(posedge clk) disable iff (!rstn)
		$fell(sel_n_q) && req_q.kind == ECIO_FAST |-> ##14 !sel_n_q ##1 sel_n_q)
		else $error("fast select width is not fifteen cycles");
	a_sync_length: assert property (@(posedge clk) disable iff (!rstn)
		$fell(sel_n_q) && req_q.kind == ECIO_SYNC |-> ##19 !sel_n_q ##1 sel_n_q)
		else $error("synchronous cycle shorter or longer than twenty");

	c_handshake_done: cover property (@(negedge ref_clock_8m)
		disable iff (!rstn) st_q == ECIO_HS_REQ && cmpl_q && !ms_n_q);
	c_paused_cycle: cover property (@(negedge ref_clock_8m)
		disable iff (!rstn) st_q == ECIO_HS_PAUSE && pcnt_q == PAUSE_LAST);
	c_strobe_write: cover property (@(posedge clk) disable iff (!rstn)
		$fell(wr_n_q) && req_q.kind == ECIO_MEDIUM);

endmodule // ecio_host

// *** tb/ecio_card.sv ***
`timescale 1ns/1ps
module ecio_card (
	input  wire logic       ref_clock_8m,
	input  wire logic       rstn,
	input  wire logic       enable,
	input  wire logic [4:0] delay,
	input  wire logic       io_request_n,
	input  wire logic       handshake_card_select_n,
	output logic            grant_pull,
	output logic            bus_latch_n
);
	logic [4:0] ticks_q;
	logic       ready_q;
	logic       latch_q;
	// Only the reference clock is used, so no phase with other clocks matters.
	always_ff @(posedge ref_clock_8m or negedge rstn) begin
		if (!rstn) begin
			ticks_q <= 5'h00;
			ready_q <= 1'b0;
		end else if (handshake_card_select_n) begin
			ticks_q <= 5'h00;
			ready_q <= 1'b0;
		end else if (!io_request_n) begin
			if (ticks_q >= delay)
				ready_q <= enable;
			else
				ticks_q <= ticks_q + 5'h01;
		end
	end
	always_ff @(posedge ref_clock_8m or negedge rstn) begin
		if (!rstn)
			latch_q <= 1'b0;
		else if (handshake_card_select_n)
			latch_q <= 1'b0;
		else if (!io_request_n)
			latch_q <= 1'b1;
	end
	// Grant follows request away, so it goes high as request rises at the terminating edge.
	assign grant_pull  = ready_q & ~io_request_n & ~handshake_card_select_n;
	assign bus_latch_n = ~latch_q;
endmodule // ecio_card

// *** tb/tb_ecio_host.sv ***
`timescale 1ns/1ps
`include "ecio_cfg.svh"
module tb_ecio_host import ecio_pkg::*; ;
	logic clk = 0, rstn = 0, ref_clock_8m = 0, valid = 0, ph2 = 1, dma = 0;
	logic card_en = 1, prev_req = 1;
	logic [4:0] card_dly = 5'h02;
	ecio_cpu_req_type cpu_req = '0;
	logic ready, done, hold, rnw_o, req_n, g_o, g_oe, hcs_n, rbe_n, wbe_n;
	logic dbe_n, sel_n, rs_n, ws_n, card_pull, latch_n, grant_n;
	logic [23:0] addr_bus;
	int mismatches = 0, checks_done = 0;
	int m_fall = 0, m_dbe = 0, m_hcs = 0, m_rbe = 0, m_wbe = 0;
	int f0, d0, h0, r0, w0, n_sel, n_str, n_lead, n_oth;
	int e_lead[4] = '{`ECIO_UP(`ECIO_SLOW_LEAD_NS), `ECIO_UP(`ECIO_MF_LEAD_NS),
		`ECIO_UP(`ECIO_MF_LEAD_NS), 0};
	int e_str[4] = '{`ECIO_UP(`ECIO_SM_STROBE_NS), `ECIO_UP(`ECIO_SM_STROBE_NS),
		`ECIO_UP(`ECIO_FAST_STROBE_NS), `ECIO_UP(`ECIO_SYNC_CYCLE_NS)};
	int e_sel[4] = '{`ECIO_UP(`ECIO_SLOW_SEL_NS), `ECIO_UP(`ECIO_MED_SEL_NS),
		`ECIO_UP(`ECIO_FAST_SEL_NS), `ECIO_UP(`ECIO_SYNC_CYCLE_NS)};
	assign grant_n = ((g_oe & ~g_o) | card_pull) ? 1'b0 : 1'b1;
	always #12.5 clk = ~clk;
	initial begin
		#3.3;
		forever #7.5 ref_clock_8m = ~ref_clock_8m;
	end
	ecio_host #(.PAUSE_MAX(3)) ecio_host_inst (.clk(clk), .rstn(rstn),
		.ref_clock_8m(ref_clock_8m), .cpu_req(cpu_req), .cpu_req_valid(valid),
		.cpu_req_ready(ready), .cpu_done(done), .cpu_clock_hold(hold),
		.processor_phase_two(ph2), .dma_refresh_pending(dma),
		.io_address_bus(addr_bus), .read_not_write(rnw_o),
		.io_request_n(req_n), .io_grant_n_i(grant_n), .io_grant_n_o(g_o),
		.io_grant_n_oe(g_oe), .handshake_card_select_n(hcs_n),
		.read_buffer_enable_n(rbe_n), .write_buffer_enable_n(wbe_n),
		.cpu_data_drive_enable_n(dbe_n), .card_select_n(sel_n),
		.card_read_strobe_n(rs_n), .card_write_strobe_n(ws_n));
	ecio_card ecio_card_inst (.ref_clock_8m(ref_clock_8m), .rstn(rstn),
		.enable(card_en), .delay(card_dly), .io_request_n(req_n),
		.handshake_card_select_n(hcs_n), .grant_pull(card_pull),
		.bus_latch_n(latch_n));
	// Link outputs change on falling reference edges; look at them on rising.
	always @(posedge ref_clock_8m) begin
		if (!req_n && prev_req) m_fall++;
		if (!dbe_n) m_dbe++;
		if (!hcs_n) m_hcs++;
		if (!rbe_n) m_rbe++;
		if (!wbe_n) m_wbe++;
		prev_req <= req_n;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic take(input logic [23:0] a, input logic r, input logic [1:0] k);
		int i;
		@(negedge clk);
		cpu_req = '{addr: a, rnw: r, kind: ecio_kind_type'(k)};
		valid = 1;
		for (i = 0; i < 50 && ready !== 1'b0; i++) @(negedge clk);
		valid = 0;
		if (ready !== 1'b0) begin
			check(ready, 0);
			stop_test();
		end
	endtask
	task automatic run(input logic [23:0] a, input logic r, input logic [1:0] k,
		input logic pz);
		int i;
		logic s_n, o_n;
		f0 = m_fall; d0 = m_dbe; h0 = m_hcs; r0 = m_rbe; w0 = m_wbe;
		n_sel = 0; n_str = 0; n_lead = 0; n_oth = 0;
		take(a, r, k);
		check(addr_bus, a);
		check(rnw_o, r);
		for (i = 0; i < 2000 && done !== 1'b1; i++) begin
			s_n = r ? rs_n : ws_n;
			o_n = r ? ws_n : rs_n;
			if (!sel_n) n_sel++;
			if (!s_n) n_str++;
			if (!sel_n && s_n && n_str == 0) n_lead++;
			if (!o_n) n_oth++;
			dma = pz && i >= 10 && i < 14;
			@(negedge clk);
		end
		dma = 0;
		check(done, 1);
		if (done !== 1'b1) begin
			stop_test();
		end else begin
			check({hold, ready}, 2'b01);
			check(g_o, 0);
			@(negedge clk);
			check(done, 0);
		end
	endtask
	task automatic t_phase();
		ph2 = 0;
		repeat (3) @(negedge clk);
		cpu_req = '{addr: 24'h000400, rnw: 1'b1, kind: ECIO_SLOW};
		valid = 1;
		repeat (4) @(negedge clk);
		check(ready, 1);
		check(hold, 0);
		valid = 0;
		ph2 = 1;
		repeat (3) @(negedge clk);
	endtask
	task automatic t_handshake();
		run(24'h000100, 1, 0, 0);
		check(m_fall - f0, 1);
		check(m_hcs > h0, 1);
		check(n_sel, 0);
		check({m_rbe > r0, m_wbe > w0}, 2'b10);
		run(24'h000104, 0, 2, 0);
		check({m_rbe > r0, m_wbe > w0}, 2'b01);
	endtask
	task automatic t_strobe();
		int k;
		for (k = 0; k < 4; k++) begin
			run(24'h200040 | 24'(k), k[1], k[1:0], 0);
			check(n_lead, e_lead[k]);
			check(n_str, e_str[k]);
			check(n_sel, e_sel[k]);
			check(n_oth, 0);
			check(m_hcs > h0, 0);
		end
	endtask
	task automatic t_pause();
		card_dly = 5'h14;
		run(24'h000200, 0, 2, 1);
		check(m_fall - f0 >= 2, 1);
		check(m_dbe > d0, 1);
		card_dly = 5'h02;
	endtask
	task automatic t_nogrant();
		int i, seen;
		card_en = 0;
		seen = 0;
		take(24'h000300, 1, 0);
		for (i = 0; i < 300; i++) begin
			@(negedge clk);
			seen += done;
		end
		check(seen, 0);
		check(hold, 1);
		rstn = 0;
		repeat (10) @(negedge clk);
		check({hold, ready, req_n, g_oe}, 4'b0110);
		rstn = 1;
		card_en = 1;
		repeat (5) @(negedge clk);
	endtask
	initial begin
		repeat (10) @(negedge clk);
		check({hold, ready, req_n, sel_n}, 4'b0111);
		rstn = 1;
		repeat (5) @(negedge clk);
		t_handshake();
		t_phase();
		t_strobe();
		t_pause();
		t_nogrant();
		t_handshake();
		stop_test();
	end
endmodule // tb_ecio_host
